// ---- hdl/rsc_ctrl.sv ----
// Overview of operation
// - Watchdog timeout resets if option set, else interrupts
// - Watchdog reset sets watchdog flag
// - Pin low four clocks guarantees reset
// - Stay reset while pin low, leave after
// - Pin reset sets pin flag
// - Internal reset drives pin low during hold
// - Debugger reset self-clears, sets power-on flag
// - Stop wake holds 66 or 5000 cycles
// - Stop wake touches only watchdog, oscillator regs
// - Stop wake selects internal oscillator
// - Fetch vector from 0002H and 0003H
// - Watchdog interrupt in stop wakes device
// - Pin or debug low in stop resets
// - Watchdog wake sets watchdog and stop flags
// - Enabled GPIO edge wakes, sets stop flag
// - Input capture only if level persists
// - Narrow pin reset pulses in stop ignored
// - Status read-only, read clears upper flags
// - Status shares address with watchdog control
// - Flags encode the reset cause
// - Power-on flag cleared by watchdog, wake, read
// - Hold 66 cycles, 5000 with crystal
// - Watchdog flag cleared by POR, GPIO wake, read
// - Pin flag cleared by POR, GPIO wake, read
`default_nettype none
`include "rsc_map.svh"
module rsc_ctrl #(
	parameter int GPIO_W    = 8,
	parameter int HOLD_LONG = 5000
) (
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	input  wire rsc_pkg::rsc_wb_req_s wb_req_i,
	output rsc_pkg::rsc_wb_rsp_s    wb_rsp_o,
	input  wire logic               reset_pin_n_i,
	output logic                    reset_pin_o,
	output logic                    reset_pin_oe_o,
	input  wire logic               debug_pin_n_i,
	input  wire logic               wdt_timeout_i,
	input  wire logic               stop_req_i,
	input  wire logic [GPIO_W-1:0]  gpio_i,
	input  wire logic [GPIO_W-1:0]  gpio_wake_en_i,
	output logic [GPIO_W-1:0]       port_input_data_o,
	output logic                    cpu_reset_o,
	output logic                    chip_reset_o,
	output logic                    wdt_irq_o,
	output logic                    ipo_select_o,
	output logic                    wdt_ctrl_we_o,
	output logic [7:0]              wdt_ctrl_data_o,
	output logic [15:0]             vector_addr_o,
	output logic                    stop_mode_o
);
	import rsc_pkg::*;

	// ****************************************
	// Input synchronisers
	// ****************************************
	logic              pin_m_q, pin_s_q, dbg_m_q, dbg_s_q;
	logic [GPIO_W-1:0] gp_m_q, gp_s_q, gp_ref_q;
	always_ff @(posedge clk_i) begin
		pin_m_q <= reset_pin_n_i;
		pin_s_q <= pin_m_q;
		dbg_m_q <= debug_pin_n_i;
		dbg_s_q <= dbg_m_q;
		gp_m_q  <= gpio_i;
		gp_s_q  <= gp_m_q;
	end

	// ****************************************
	// Registers and wires
	// ****************************************
	rsc_state_e  state_q;
	logic [7:0]  status_q;
	logic [7:0]  mode_q;
	logic        dbg_req_q;
	logic        ack_q;
	logic [31:0] rdat_q;
	logic [12:0] hold_q;
	logic [2:0]  low_q;
	logic        pin_hold_q;
	logic        drive_q;
	logic        was_stop_q;
	logic        gp_wake_q;

	wire bus_req  = wb_req_i.cyc && wb_req_i.stb && !ack_q;
	wire wr       = bus_req && wb_req_i.we && wb_req_i.sel[0];
	wire rd       = bus_req && !wb_req_i.we;
	wire a_stat   = wb_req_i.adr == `RSC_ADDR_STATUS;
	wire a_dbg    = wb_req_i.adr == `RSC_ADDR_DBG_CTRL;
	wire a_mode   = wb_req_i.adr == `RSC_ADDR_MODE;
	wire stat_rd  = rd && a_stat;
	wire in_stop  = state_q == RSC_STOP;
	wire wdt_rst  = wdt_timeout_i && mode_q[`RSC_BIT_WATCHDOG_RESET_SELECT_OPTION];
	wire wdt_int  = wdt_timeout_i && !mode_q[`RSC_BIT_WATCHDOG_RESET_SELECT_OPTION];
	// Four synchronised low samples qualify the pin
	// Own drive of the pin must not read back as an external reset
	wire pin_rst  = !drive_q && !pin_s_q &&
	                low_q == (`RSC_PIN_MIN_CYC - 3'd1);
	wire dbg_rst  = in_stop && !dbg_s_q;
	wire gp_evt   = in_stop && |((gp_s_q ^ gp_ref_q) & gpio_wake_en_i);
	wire wdt_wake = in_stop && wdt_timeout_i;
	wire int_rst  = (wdt_rst && !in_stop) || dbg_req_q || dbg_rst;
	wire any_rst  = int_rst || pin_rst;
	wire wake     = !any_rst && (gp_evt || wdt_wake);
	wire [12:0] hold_len = mode_q[`RSC_BIT_XTAL] ? 13'(HOLD_LONG)
	                                             : `RSC_HOLD_SHORT;
	wire hold_done = hold_q == 13'h0000 && !(pin_hold_q && !pin_s_q);

	// ****************************************
	// Pin low-width counter
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i || pin_s_q)
			low_q <= 3'd0;
		else if (low_q != 3'd7)
			low_q <= low_q + 3'd1;
	end

	// ****************************************
	// Sequencer
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q    <= RSC_HOLD;
			// Loaded one short: the exit edge is the last held cycle
			hold_q     <= `RSC_HOLD_SHORT - 13'd1;
			pin_hold_q <= 1'b0;
			drive_q    <= 1'b1;
			was_stop_q <= 1'b0;
			gp_wake_q  <= 1'b0;
		end else if (any_rst) begin
			state_q    <= RSC_HOLD;
			hold_q     <= hold_len - 13'd1;
			pin_hold_q <= pin_rst;
			drive_q    <= int_rst;
			was_stop_q <= 1'b0;
			gp_wake_q  <= 1'b0;
		end else begin
			case (state_q)
				RSC_RUN: begin
					if (stop_req_i)
						state_q <= RSC_STOP;
				end
				RSC_STOP: begin
					if (wake) begin
						state_q    <= RSC_HOLD;
						hold_q     <= hold_len - 13'd1;
						was_stop_q <= 1'b1;
						gp_wake_q  <= gp_evt && !wdt_wake;
					end
				end
				RSC_HOLD: begin
					if (hold_q != 13'h0000)
						hold_q <= hold_q - 13'd1;
					else if (hold_done) begin
						state_q <= RSC_RUN;
						drive_q <= 1'b0;
					end
				end
				default: state_q <= RSC_HOLD;
			endcase
		end
	end

	// Reference level frozen in stop so any edge is seen
	always_ff @(posedge clk_i) begin
		if (!in_stop)
			gp_ref_q <= gp_s_q;
	end

	// Frozen in stop and during hold, captured from the end of hold on, so short pulses vanish
	always_ff @(posedge clk_i) begin
		if (rst_i)
			port_input_data_o <= '0;
		else if (state_q != RSC_STOP && !(state_q == RSC_HOLD && !hold_done))
			port_input_data_o <= gp_s_q;
	end

	// ****************************************
	// Status flags
	// ****************************************
	logic [7:0] st_d;
	always_comb begin
		st_d = status_q;
		if (stat_rd)
			st_d[7:4] = 4'h0;
		if (wdt_timeout_i)
			st_d[`RSC_BIT_POR] = 1'b0;
		if (wdt_timeout_i && !in_stop)
			st_d[`RSC_BIT_STOP] = 1'b0;
		if (pin_rst) begin
			st_d[7:4] = 4'h1;
		end else if (dbg_req_q || dbg_rst) begin
			st_d[7:4] = 4'h8;
		end else if (wdt_rst && !in_stop) begin
			st_d[7:4] = 4'h2;
		end else if (wake && wdt_wake) begin
			st_d[7:4] = 4'h6;
		end else if (wake) begin
			st_d[7:4] = 4'h4;
		end else if (wdt_int) begin
			st_d[`RSC_BIT_WDT] = 1'b1;
		end
		st_d[3:0] = 4'h0;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			status_q <= `RSC_STATUS_RESET;
		else
			status_q <= st_d;
	end

	// ****************************************
	// Wishbone slave
	// ****************************************
	// Mode register lives through system reset; only rst_i resets it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_q    <= `RSC_MODE_RESET;
			dbg_req_q <= 1'b0;
		end else begin
			if (wr && a_mode)
				mode_q <= wb_req_i.dat[7:0];
			if (dbg_req_q)
				dbg_req_q <= 1'b0;
			else if (wr && a_dbg)
				dbg_req_q <= wb_req_i.dat[`RSC_BIT_DBG_RST];
		end
	end

	wire [31:0] rd_mux = a_stat ? {24'h000000, status_q} :
	                     a_mode ? {24'h000000, mode_q}   : 32'h00000000;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q  <= 1'b0;
			rdat_q <= 32'h00000000;
		end else begin
			ack_q  <= bus_req;
			rdat_q <= rd ? rd_mux : 32'h00000000;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wdt_ctrl_we_o   <= 1'b0;
			wdt_ctrl_data_o <= 8'h00;
		end else begin
			wdt_ctrl_we_o   <= wr && a_stat;
			wdt_ctrl_data_o <= wb_req_i.dat[7:0];
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign wb_rsp_o       = '{ack: ack_q, dat: rdat_q};
	assign reset_pin_o    = 1'b0;
	assign reset_pin_oe_o = drive_q;
	assign cpu_reset_o    = state_q == RSC_HOLD;
	// Stop wake leaves other registers alone
	assign chip_reset_o   = state_q == RSC_HOLD && !was_stop_q;
	assign ipo_select_o   = state_q == RSC_HOLD;
	assign wdt_irq_o      = wdt_int && mode_q[`RSC_BIT_IRQ_EN];
	assign vector_addr_o  = cpu_reset_o ? `RSC_VECTOR_LO
	                                    : `RSC_VECTOR_HI;
	assign stop_mode_o    = in_stop;
endmodule
`default_nettype wire

// ---- hdl/rsc_map.svh ----
`ifndef RSC_MAP_SVH
`define RSC_MAP_SVH
// Register byte addresses on the Wishbone bus
`define RSC_ADDR_STATUS     12'hFF0
`define RSC_ADDR_WDT_CTRL   12'hFF0
`define RSC_ADDR_DBG_CTRL   12'hFF4
`define RSC_ADDR_MODE       12'hFF8
// Status field positions
`define RSC_BIT_POR         7
`define RSC_BIT_STOP        6
`define RSC_BIT_WDT         5
`define RSC_BIT_EXT         4
// Debug control request bit
`define RSC_BIT_DBG_RST     0
// Mode register bits
`define RSC_BIT_XTAL        0
`define RSC_BIT_WATCHDOG_RESET_SELECT_OPTION     1
`define RSC_BIT_IRQ_EN      2
// Reset values
`define RSC_STATUS_RESET    8'h80
`define RSC_MODE_RESET      8'h02
// Timing
`define RSC_HOLD_SHORT      13'd66
`define RSC_HOLD_LONG       13'd5000
`define RSC_PIN_MIN_CYC     3'd4
`define RSC_VECTOR_LO       16'h0002
`define RSC_VECTOR_HI       16'h0003
`endif

// ---- hdl/rsc_pkg.sv ----
`default_nettype none
package rsc_pkg;
	typedef enum logic [1:0] {
		RSC_RUN,
		RSC_STOP,
		RSC_HOLD
	} rsc_state_e;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [11:0] adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} rsc_wb_req_s;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} rsc_wb_rsp_s;
endpackage
`default_nettype wire

// ---- test/rsc_ctrl_checker.sv ----
`default_nettype none
module rsc_ctrl_checker #(
	parameter int GPIO_W = 8
) (
	input wire logic                 clk_i,
	input wire logic                 rst_i,
	input wire rsc_pkg::rsc_wb_req_s wb_req_i,
	input wire rsc_pkg::rsc_wb_rsp_s wb_rsp_o,
	input wire logic                 reset_pin_n_i,
	input wire logic                 reset_pin_o,
	input wire logic                 reset_pin_oe_o,
	input wire logic                 wdt_timeout_i,
	input wire logic                 wdt_irq_o,
	input wire logic                 cpu_reset_o,
	input wire logic                 ipo_select_o,
	input wire logic [15:0]          vector_addr_o,
	input wire logic                 stop_mode_o,
	input wire logic [GPIO_W-1:0]    port_input_data_o,
	input wire logic                 wdt_ctrl_we_o,
	input wire logic [7:0]           wdt_ctrl_data_o
);
	timeunit 1ns;
	timeprecision 1ns;
	import rsc_pkg::*;
	// ****
	// Bus, hold length and output checks
	// ****
	logic [15:0] hcnt_q;
	always_ff @(posedge clk_i) begin
		if (rst_i || !cpu_reset_o) hcnt_q <= 16'h0;
		else hcnt_q <= hcnt_q + 16'h1;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	ack_pulse_a: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
		else $error("ack longer than one cycle");
	ack_answer_a: assert property (
		wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack |=> wb_rsp_o.ack)
		else $error("no ack one cycle after request");
	ctrl_write_a: assert property (wb_rsp_o.ack && wb_req_i.we &&
		wb_req_i.adr == 12'hFF0 && wb_req_i.sel[0] |->
		wdt_ctrl_we_o && wdt_ctrl_data_o == wb_req_i.dat[7:0])
		else $error("watchdog control write lost");
	irq_cause_a: assert property (wdt_irq_o |-> wdt_timeout_i)
		else $error("watchdog interrupt without time-out");
	pin_qual_a: assert property (
		(!reset_pin_n_i && !reset_pin_oe_o) [*8] |-> cpu_reset_o)
		else $error("long pin low did not reset");
	pin_drive_a: assert property (reset_pin_oe_o |-> !reset_pin_o)
		else $error("reset pin driven high");
	clk_sel_a: assert property (cpu_reset_o |-> ipo_select_o)
		else $error("internal oscillator not selected");
	vec_addr_a: assert property (
		cpu_reset_o |-> vector_addr_o == 16'h0002)
		else $error("wrong vector address in hold");
	cap_freeze_a: assert property (
		stop_mode_o |=> $stable(port_input_data_o))
		else $error("input capture changed in stop");
	hold_len_a: assert property ($fell(cpu_reset_o) |-> hcnt_q >= 16'd66)
		else $error("hold shorter than 66 cycles");
	cover property ($fell(cpu_reset_o));
	cover property (stop_mode_o ##1 cpu_reset_o);
	cover property (wdt_irq_o);
endmodule
bind rsc_ctrl rsc_ctrl_checker #(.GPIO_W(GPIO_W)) chk_i (.clk_i, .rst_i,
	.wb_req_i, .wb_rsp_o, .reset_pin_n_i, .reset_pin_o, .reset_pin_oe_o,
	.wdt_timeout_i, .wdt_irq_o, .cpu_reset_o, .ipo_select_o,
	.vector_addr_o, .stop_mode_o, .port_input_data_o, .wdt_ctrl_we_o,
	.wdt_ctrl_data_o);
`default_nettype wire

// ---- test/rsc_board_model.sv ----
`default_nettype none
module rsc_board_model (
	input  wire logic dut_oe_i,
	input  wire logic ext_low_i,
	output logic      pin_n_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Pull-up wins unless some party sinks the line
	assign pin_n_o = !(dut_oe_i || ext_low_i);
endmodule
`default_nettype wire

// ---- test/test_reset_and_stop_recovery_control.sv ----
`default_nettype none
module test_reset_and_stop_recovery_control;
	timeunit 1ns;
	timeprecision 1ns;
	import rsc_pkg::*;
	logic        clk_i = 1'h0, rst_i = 1'h1, ext_low = 1'h0, wdt_to = 1'h0;
	logic        stop_req = 1'h0, dbg_n = 1'h1;
	logic        pin_n, oe, cres, irq, stp, chip;
	logic [7:0]  gpio = 8'h00;
	logic [7:0]  pid;
	logic [31:0] q;
	int          err_count = 0, checks_done = 0;
	rsc_wb_req_s req = '0;
	rsc_wb_rsp_s rsp;
	rsc_ctrl #(.GPIO_W(8), .HOLD_LONG(100)) dut (.clk_i, .rst_i,
		.wb_req_i(req), .wb_rsp_o(rsp), .reset_pin_n_i(pin_n),
		.reset_pin_o(), .reset_pin_oe_o(oe), .debug_pin_n_i(dbg_n),
		.wdt_timeout_i(wdt_to), .stop_req_i(stop_req), .gpio_i(gpio),
		.gpio_wake_en_i(8'h01), .port_input_data_o(pid), .cpu_reset_o(cres),
		.chip_reset_o(chip), .wdt_irq_o(irq), .ipo_select_o(),
		.wdt_ctrl_we_o(), .wdt_ctrl_data_o(), .vector_addr_o(),
		.stop_mode_o(stp));
	rsc_board_model brd (.dut_oe_i(oe), .ext_low_i(ext_low), .pin_n_o(pin_n));
	initial forever #50 clk_i = ~clk_i;
	// ****
	// Tasks
	// ****
	task automatic results;
		$display("errors %0d checks %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, e);
		checks_done++;
		if (s !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic tmo;
		err_count++;
		results();
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
		int i;
		@(posedge clk_i);
		req <= '{1'h1, 1'h1, w, a, 4'h1, {24'h0, d}};
		for (i = 0; i < 20; i++) begin
			@(posedge clk_i);
			if (rsp.ack === 1'h1) break;
		end
		if (i == 20) tmo();
		q = rsp.dat;
		req <= '0;
	endtask
	task automatic rd(input logic [7:0] e);
		bus(1'h0, 12'hFF0, 8'h00);
		chk("status", q, {24'h0, e});
	endtask
	// Counts sampled hold cycles; bounded so a stuck hold ends the run
	task automatic hold(output int n);
		int i;
		n = 0;
		for (i = 0; i < 3000 && (n == 0 || cres === 1'h1); i++) begin
			@(posedge clk_i);
			if (cres === 1'h1) n++;
		end
		if (i == 3000) tmo();
	endtask
	task automatic wdt(input logic e);
		@(posedge clk_i);
		wdt_to <= 1'h1;
		@(negedge clk_i);
		chk("irq", irq, e);
		@(posedge clk_i);
		wdt_to <= 1'h0;
	endtask
	task automatic stop;
		@(posedge clk_i);
		stop_req <= 1'h1;
		@(posedge clk_i);
		stop_req <= 1'h0;
		repeat (3) @(posedge clk_i);
		chk("stop", stp, 1'h1);
	endtask
	initial begin
		int n;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'h0;
		hold(n);
		rd(8'h80);
		rd(8'h00);
		bus(1'h1, 12'hFF0, 8'h5A);
		rd(8'h00);
		bus(1'h0, 12'hFFC, 8'h00);
		chk("unmapped", q, 32'h0);
		wdt(1'h0);
		repeat (5) @(posedge clk_i);
		chk("pin drive", pin_n, 1'h0);
		hold(n);
		rd(8'h20);
		for (int k = 4; k < 300; k += 196) begin
			ext_low <= 1'h1;
			repeat (k) @(posedge clk_i);
			chk("held", cres, k > 4);
			ext_low <= 1'h0;
			hold(n);
			rd(8'h10);
		end
		bus(1'h1, 12'hFF4, 8'h01);
		@(negedge clk_i);
		chk("chip reset", chip, 1'h1);
		hold(n);
		rd(8'h80);
		bus(1'h1, 12'hFF8, 8'h05);
		wdt(1'h1);
		repeat (3) @(posedge clk_i);
		chk("no reset", cres, 1'h0);
		rd(8'h20);
		stop();
		gpio <= 8'h01;
		hold(n);
		chk("long hold", n, 100);
		chk("capture", pid, 8'h01);
		rd(8'h40);
		bus(1'h1, 12'hFF8, 8'h04);
		stop();
		wdt(1'h1);
		@(negedge clk_i);
		chk("chip reset", chip, 1'h0);
		hold(n);
		chk("short hold", n, 66);
		rd(8'h60);
		bus(1'h0, 12'hFF8, 8'h00);
		chk("mode kept", q, 32'h4);
		stop();
		ext_low <= 1'h1;
		repeat (2) @(posedge clk_i);
		ext_low <= 1'h0;
		repeat (6) @(posedge clk_i);
		chk("pulse ignored", stp, 1'h1);
		dbg_n <= 1'h0;
		hold(n);
		dbg_n <= 1'h1;
		rd(8'h80);
		results();
	end
endmodule
`default_nettype wire
